// ===== lsc_switch_ctrl.sv
`timescale 1ns/10ps
`include "lsc_params.svh"
module lsc_switch_ctrl #(
  parameter int unsigned PULSE_CYC  = `LSC_TERM_PULSE_CYC,
  parameter int unsigned UPDATE_CYC = `LSC_UPDATE_DELAY_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 addr_select_pin,
  input  wire logic [6:0]           bus_addr,
  input  wire logic                 wr_strobe,
  input  wire lsc_pkg::lsc_cfg_type wr_cfg,
  output logic                      addr_match,
  output lsc_pkg::lsc_cfg_type      shadow_cfg,
  output lsc_pkg::lsc_cfg_type      active_cfg,
  output logic                      update_pending,
  output logic [3:0]                hs_out_enable,
  output logic [3:0]                hs_route_b,
  output logic [7:0]                input_term_connect,
  output logic [7:0]                input_eq_12db,
  output logic                      out_term_connect,
  output logic                      out_current_20ma,
  output logic [1:0]                out_preemphasis,
  output logic                      aux_route_b,
  output logic                      aux_connect
);
  localparam lsc_pkg::lsc_cfg_type RST_CFG = '{
    hs_switch_enable:         `LSC_RST_HS_ENABLE,
    hs_source_select:         `LSC_RST_HS_SELECT,
    aux_switch_enable:        `LSC_RST_AUX_ENABLE,
    aux_source_select:        `LSC_RST_AUX_SELECT,
    input_term_pulse:         `LSC_RST_TERM_PULSE,
    input_term_off:           `LSC_RST_TERM_OFF,
    input_equalizer_level:    `LSC_RST_EQ,
    output_term_on:           `LSC_RST_OUT_TERM_ON,
    output_current_level:     `LSC_RST_OUT_CURRENT,
    output_preemphasis_level: `LSC_RST_PREEMPH
  };

  logic                  sel_meta_ff;
  logic                  sel_sync_ff;
  logic                  match_ff;
  logic                  nxt_match;
  lsc_pkg::lsc_cfg_type  shadow_ff;
  lsc_pkg::lsc_cfg_type  nxt_shadow;
  lsc_pkg::lsc_cfg_type  active_ff;
  lsc_pkg::lsc_cfg_type  nxt_active;
  lsc_pkg::lsc_upd_type  state_ff;
  lsc_pkg::lsc_upd_type  nxt_state;
  logic [`LSC_CNT_W-1:0] win_ff;
  logic [`LSC_CNT_W-1:0] nxt_win;
  logic                  pulse_start;
  logic                  pulse_active;
  logic [3:0]            hs_switch_enable_ff;
  logic [3:0]            nxt_hs_switch_enable;
  logic [3:0]            hs_b_ff;
  logic [3:0]            nxt_hs_b;
  logic [7:0]            term_ff;
  logic [7:0]            nxt_term;
  logic [7:0]            eq_ff;
  logic [7:0]            nxt_eq;
  logic                  oterm_ff;
  logic                  nxt_oterm;
  logic                  ocur_ff;
  logic                  nxt_ocur;
  logic [1:0]            pe_ff;
  logic [1:0]            nxt_pe;
  logic                  aux_b_ff;
  logic                  nxt_aux_b;
  logic                  aux_en_ff;
  logic                  nxt_aux_en;

  function automatic logic [3:0] lsc_fan4(input logic v);
    lsc_fan4 = {4{v}};
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sel_meta_ff <= 1'b0;
      sel_sync_ff <= 1'b0;
    end else begin
      sel_meta_ff <= addr_select_pin;
      sel_sync_ff <= sel_meta_ff;
    end
  end

  always_comb begin
    nxt_match = (bus_addr == {`LSC_ADDR_UPPER, sel_sync_ff});
  end

  // shadow holds written values; active takes an idle write at once and, at window end, a same-cycle write or else the shadow
  always_comb begin
    nxt_shadow  = shadow_ff;
    nxt_active  = active_ff;
    nxt_state   = state_ff;
    nxt_win     = win_ff;
    pulse_start = 1'b0;
    if (wr_strobe) begin
      nxt_shadow = wr_cfg;
    end
    unique case (state_ff)
      lsc_pkg::LSC_IDLE: begin
        if (wr_strobe) begin
          nxt_active  = wr_cfg;
          pulse_start = (wr_cfg.hs_source_select != active_ff.hs_source_select);
          nxt_state   = lsc_pkg::LSC_WINDOW;
          nxt_win     = `LSC_CNT_W'(UPDATE_CYC - 1);
        end
      end
      lsc_pkg::LSC_WINDOW: begin
        if (win_ff == '0) begin
          nxt_active  = wr_strobe ? wr_cfg : shadow_ff;
          pulse_start = (nxt_active.hs_source_select != active_ff.hs_source_select);
          nxt_state   = lsc_pkg::LSC_IDLE;
        end else begin
          nxt_win = win_ff - `LSC_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_ff <= RST_CFG;
      active_ff <= RST_CFG;
      state_ff  <= lsc_pkg::LSC_IDLE;
      win_ff    <= '0;
      match_ff  <= 1'b0;
    end else begin
      shadow_ff <= nxt_shadow;
      active_ff <= nxt_active;
      state_ff  <= nxt_state;
      win_ff    <= nxt_win;
      match_ff  <= nxt_match;
    end
  end

  lsc_term_pulse #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pulse (
    .mclk    (mclk),
    .reset_n (reset_n),
    .start   (pulse_start),
    .active  (pulse_active)
  );

  // analog controls, registered so every output leaves a flip-flop
  always_comb begin
    nxt_hs_switch_enable  = lsc_fan4(active_ff.hs_switch_enable);
    nxt_hs_b   = lsc_fan4(active_ff.hs_source_select);
    nxt_term   = {`LSC_NUM_IN_CH{~active_ff.input_term_off}}
               & ~({`LSC_NUM_IN_CH{pulse_active}} & active_ff.input_term_pulse);
    nxt_eq     = active_ff.input_equalizer_level;
    nxt_oterm  = active_ff.output_term_on;
    nxt_ocur   = active_ff.output_current_level;
    nxt_pe     = active_ff.output_preemphasis_level;
    nxt_aux_b  = active_ff.aux_source_select;
    nxt_aux_en = active_ff.aux_switch_enable;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hs_switch_enable_ff  <= {4{`LSC_RST_HS_ENABLE}};
      hs_b_ff   <= {4{`LSC_RST_HS_SELECT}};
      term_ff   <= `LSC_RST_TERM_CONNECT;
      eq_ff     <= `LSC_RST_EQ;
      oterm_ff  <= `LSC_RST_OUT_TERM_ON;
      ocur_ff   <= `LSC_RST_OUT_CURRENT;
      pe_ff     <= `LSC_RST_PREEMPH;
      aux_b_ff  <= `LSC_RST_AUX_SELECT;
      aux_en_ff <= `LSC_RST_AUX_ENABLE;
    end else begin
      hs_switch_enable_ff  <= nxt_hs_switch_enable;
      hs_b_ff   <= nxt_hs_b;
      term_ff   <= nxt_term;
      eq_ff     <= nxt_eq;
      oterm_ff  <= nxt_oterm;
      ocur_ff   <= nxt_ocur;
      pe_ff     <= nxt_pe;
      aux_b_ff  <= nxt_aux_b;
      aux_en_ff <= nxt_aux_en;
    end
  end

  assign addr_match         = match_ff;
  assign shadow_cfg         = shadow_ff;
  assign active_cfg         = active_ff;
  assign update_pending     = (state_ff == lsc_pkg::LSC_WINDOW);
  assign hs_out_enable      = hs_switch_enable_ff;
  assign hs_route_b         = hs_b_ff;
  assign input_term_connect = term_ff;
  assign input_eq_12db      = eq_ff;
  assign out_term_connect   = oterm_ff;
  assign out_current_20ma   = ocur_ff;
  assign out_preemphasis    = pe_ff;
  assign aux_route_b        = aux_b_ff;
  assign aux_connect        = aux_en_ff;
endmodule

// ===== lsc_params.svh
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH

`define LSC_ADDR_UPPER        6'h24
`define LSC_CLK_MHZ           100
`define LSC_TERM_PULSE_MS     100
`define LSC_TERM_PULSE_CYC    (`LSC_TERM_PULSE_MS * 1000 * `LSC_CLK_MHZ)
`define LSC_UPDATE_DELAY_US   10
`define LSC_UPDATE_DELAY_CYC  (`LSC_UPDATE_DELAY_US * `LSC_CLK_MHZ)
`define LSC_CNT_W             24
`define LSC_NUM_IN_CH         8
`define LSC_GRP_CH            4
`define LSC_RST_HS_ENABLE     1'h1
`define LSC_RST_HS_SELECT     1'h0
`define LSC_RST_AUX_ENABLE    1'h1
`define LSC_RST_AUX_SELECT    1'h0
`define LSC_RST_TERM_PULSE    8'h00
`define LSC_RST_TERM_OFF      1'h0
`define LSC_RST_TERM_CONNECT  8'hFF
`define LSC_RST_EQ            8'h00
`define LSC_RST_OUT_TERM_ON   1'h1
`define LSC_RST_OUT_CURRENT   1'h1
`define LSC_RST_PREEMPH       2'h0

`endif

// ===== lsc_pkg.sv
package lsc_pkg;
  typedef struct packed {
    logic       hs_switch_enable;
    logic       hs_source_select;
    logic       aux_switch_enable;
    logic       aux_source_select;
    logic [7:0] input_term_pulse;
    logic       input_term_off;
    logic [7:0] input_equalizer_level;
    logic       output_term_on;
    logic       output_current_level;
    logic [1:0] output_preemphasis_level;
  } lsc_cfg_type;

  typedef enum logic [0:0] {
    LSC_IDLE   = 1'b0,
    LSC_WINDOW = 1'b1
  } lsc_upd_type;
endpackage

// ===== lsc_term_pulse.sv
`timescale 1ns/10ps
`include "lsc_params.svh"
module lsc_term_pulse #(
  parameter int unsigned PULSE_CYC = `LSC_TERM_PULSE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       start,
  output logic            active
);
  logic [`LSC_CNT_W-1:0] cnt_ff;
  logic [`LSC_CNT_W-1:0] nxt_cnt;
  logic                  active_ff;
  logic                  nxt_active;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_active = active_ff;
    if (start) begin
      nxt_cnt    = `LSC_CNT_W'(PULSE_CYC - 1);
      nxt_active = 1'b1;
    end else if (active_ff) begin
      if (cnt_ff == '0) begin
        nxt_active = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - `LSC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff    <= '0;
      active_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      active_ff <= nxt_active;
    end
  end

  assign active = active_ff;
endmodule

// ===== lsc_switch_ctrl_sva.sv
`timescale 1ns/10ps
module lsc_switch_ctrl_sva (
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire logic [6:0]           bus_addr,
  input wire logic                 addr_match,
  input wire logic                 wr_strobe,
  input wire lsc_pkg::lsc_cfg_type wr_cfg,
  input wire lsc_pkg::lsc_cfg_type shadow_cfg,
  input wire lsc_pkg::lsc_cfg_type active_cfg,
  input wire logic                 update_pending,
  input wire logic [3:0]           hs_out_enable,
  input wire logic [3:0]           hs_route_b,
  input wire logic [7:0]           input_term_connect,
  input wire logic [7:0]           input_eq_12db
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_addr_fixed: assert property (
    addr_match |-> $past(bus_addr[6:1]) == 6'h24) else $error("bad address match");
  a_idle_apply: assert property (
    wr_strobe && !update_pending |=> update_pending && active_cfg == $past(wr_cfg))
    else $error("idle write not applied");
  a_window_hold: assert property (
    update_pending && $past(update_pending) |-> $stable(active_cfg))
    else $error("applied values moved in window");
  a_window_len: assert property (
    $rose(update_pending) |-> update_pending [*8] ##1 !update_pending)
    else $error("window length wrong");
  a_shadow_write: assert property (
    wr_strobe |=> shadow_cfg == $past(wr_cfg)) else $error("shadow not written");
  a_route_follow: assert property (
    {hs_out_enable, hs_route_b} == {{4{$past(active_cfg.hs_switch_enable)}},
    {4{$past(active_cfg.hs_source_select)}}}) else $error("route or enable wrong");
  a_eq_follow: assert property (
    input_eq_12db == $past(active_cfg.input_equalizer_level)) else $error("eq wrong");
  a_term_off: assert property (
    $past(active_cfg.input_term_off) |-> input_term_connect == 8'h00)
    else $error("termination not off");
  a_pulse_mask: assert property (
    !$past(active_cfg.input_term_off) |->
    (input_term_connect | $past(active_cfg.input_term_pulse)) == 8'hFF)
    else $error("unpulsed termination off");
  c_window: cover property (wr_strobe && update_pending);
  c_idle: cover property ($rose(update_pending));
  c_pulse: cover property ($fell(input_term_connect[7]));
endmodule
bind lsc_switch_ctrl lsc_switch_ctrl_sva u_sva (.mclk, .reset_n, .bus_addr, .addr_match,
  .wr_strobe, .wr_cfg, .shadow_cfg, .active_cfg, .update_pending, .hs_out_enable,
  .hs_route_b, .input_term_connect, .input_eq_12db);

// ===== lsc_host_model.sv
`timescale 1ns/10ps
module lsc_host_model #(
  parameter bit EXT_TERM = 1'h0
) (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 req,
  input  wire lsc_pkg::lsc_cfg_type req_cfg,
  output logic                      wr_strobe,
  output lsc_pkg::lsc_cfg_type      wr_cfg
);
  lsc_pkg::lsc_cfg_type nxt_cfg;
  always_comb begin
    nxt_cfg = req_cfg;
    nxt_cfg.output_current_level = req_cfg.output_term_on;
    if (!req_cfg.output_term_on && !EXT_TERM) begin
      nxt_cfg.hs_switch_enable = 1'h0;
    end
  end
  // idle bus toggles each cycle between the last word and its inverse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_strobe <= 1'h0;
      wr_cfg    <= '0;
    end else begin
      wr_strobe <= req;
      wr_cfg    <= req ? nxt_cfg : ~wr_cfg;
    end
  end
endmodule

// ===== lsc_switch_ctrl_tb_top.sv
`timescale 1ns/10ps
module lsc_switch_ctrl_tb_top;
  logic                 mclk, reset_n, addr_select_pin, wr_strobe, addr_match, req;
  logic                 update_pending, out_term_connect, out_current_20ma;
  logic                 aux_route_b, aux_connect;
  logic [6:0]           bus_addr;
  logic [3:0]           hs_out_enable, hs_route_b;
  logic [7:0]           input_term_connect, input_eq_12db;
  logic [1:0]           out_preemphasis;
  lsc_pkg::lsc_cfg_type wr_cfg, shadow_cfg, active_cfg, req_cfg, dflt, c;
  int                   errors, n_tests, k, cnt;
  lsc_switch_ctrl #(.PULSE_CYC(20), .UPDATE_CYC(8)) dut (.mclk, .reset_n, .addr_select_pin,
    .bus_addr, .wr_strobe, .wr_cfg, .addr_match, .shadow_cfg, .active_cfg, .update_pending,
    .hs_out_enable, .hs_route_b, .input_term_connect, .input_eq_12db, .out_term_connect,
    .out_current_20ma, .out_preemphasis, .aux_route_b, .aux_connect);
  lsc_host_model host (.mclk, .reset_n, .req, .req_cfg, .wr_strobe, .wr_cfg);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input lsc_pkg::lsc_cfg_type v);
    @(posedge mclk);
    req     <= 1'h1;
    req_cfg <= v;
    @(posedge mclk);
    req <= 1'h0;
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
    cnt = 0;
    while (update_pending !== 1'h0 && cnt < 50) begin
      @(posedge mclk);
      cnt++;
    end
    if (cnt == 50) begin
      errors++;
      stop_test;
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    errors = 0;
    n_tests = 0;
    reset_n = 1'h0;
    addr_select_pin = 1'h1;
    bus_addr = 7'h49;
    req = 1'h0;
    dflt = {1'h1, 1'h0, 1'h1, 1'h0, 8'h00, 1'h0, 8'h00, 1'h1, 1'h1, 2'h0};
    req_cfg = dflt;
    repeat (16) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (4) @(posedge mclk);
    #1;
    chk(active_cfg, dflt);
    chk({hs_out_enable, hs_route_b, input_term_connect}, 16'hF0FF);
    chk({out_term_connect, out_current_20ma, aux_route_b}, 3'h6);
    chk(addr_match, 1'h1);
    @(posedge mclk);
    bus_addr <= 7'h48;
    repeat (2) @(posedge mclk);
    #1;
    chk(addr_match, 1'h0);
    @(posedge mclk);
    addr_select_pin <= 1'h0;
    repeat (4) @(posedge mclk);
    #1;
    chk(addr_match, 1'h1);
    $display("test reset and address done");
    c = dflt;
    c.hs_source_select = 1'h1;
    c.input_term_pulse = 8'hF0;
    c.input_equalizer_level = 8'hA5;
    wr(c);
    cnt = 0;
    repeat (60) begin
      @(posedge mclk);
      #1;
      if (input_term_connect === 8'h0F) cnt++;
    end
    chk(cnt, 20);
    chk({hs_route_b, input_eq_12db, aux_route_b}, 13'h1F4A);
    for (k = 0; k < 4; k++) begin
      c.output_preemphasis_level = k[1:0];
      c.aux_source_select = k[0];
      wr(c);
      settle;
      chk({out_preemphasis, aux_route_b, hs_route_b}, {k[1:0], k[0], 4'hF});
    end
    $display("test routing done");
    c.input_equalizer_level = 8'h3C;
    wr(c);
    c.input_equalizer_level = 8'hFF;
    wr(c);
    repeat (2) @(posedge mclk);
    #1;
    chk(input_eq_12db, 8'h3C);
    chk(shadow_cfg, c);
    chk(update_pending, 1'h1);
    settle;
    chk(input_eq_12db, 8'hFF);
    chk(active_cfg, c);
    $display("test window done");
    c.input_term_off = 1'h1;
    c.output_term_on = 1'h0;
    c.aux_switch_enable = 1'h0;
    wr(c);
    settle;
    chk({input_term_connect, out_term_connect}, 9'h000);
    chk({hs_out_enable, out_current_20ma, aux_connect}, 6'h00);
    @(posedge mclk);
    reset_n <= 1'h0;
    @(posedge mclk);
    #1;
    chk(active_cfg, dflt);
    chk({hs_route_b, input_term_connect}, 12'h0FF);
    @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    chk({update_pending, aux_connect, hs_out_enable}, 6'h1F);
    c = dflt;
    c.hs_source_select = 1'h1;
    c.input_term_pulse = 8'h0F;
    wr(c);
    settle;
    chk(active_cfg, c);
    chk({hs_route_b, input_term_connect}, 12'hFF0);
    $display("test terminations and reset done");
    stop_test;
  end
endmodule
